//--- pie_pkg.sv
package pie_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	// Printed offsets are not all multiples of four: byte address is 4*index
	localparam logic [7:0] IDX_ENABLE_HI = 8'h11;
	localparam logic [7:0] IDX_ENABLE_LO = 8'h17;
	localparam logic [7:0] IDX_FLAGS_LO  = 8'h18;
	localparam logic [7:0] IDX_FLAGS_HI  = 8'h19;
	localparam logic [7:0] IDX_STATUS    = 8'h1a;
	localparam logic [7:0] RST_ENABLE_HI = 8'h00;
	localparam logic [7:0] RST_ENABLE_LO = 8'h00;
	// Unimplemented bit of the high enable register
	localparam logic [7:0] MASK_ENABLE_HI = 8'hef;

	// ----------------------------------------------------------------
	// Field positions, low register
	// ----------------------------------------------------------------
	localparam int BIT_PORT_CHANGE = 7;
	localparam int BIT_TIMER_THREE = 6;
	localparam int BIT_TIMER_TWO   = 5;
	localparam int BIT_TIMER_ONE   = 4;
	localparam int BIT_CAPTURE_TWO = 3;
	localparam int BIT_CAPTURE_ONE = 2;
	localparam int BIT_SER_ONE_TX  = 1;
	localparam int BIT_SER_ONE_RX  = 0;

	// ----------------------------------------------------------------
	// Field positions, high register
	// ----------------------------------------------------------------
	localparam int BIT_SYNC_SERIAL   = 7;
	localparam int BIT_BUS_COLLISION = 6;
	localparam int BIT_CONVERTER     = 5;
	localparam int BIT_UNUSED_HI     = 4;
	localparam int BIT_CAPTURE_FOUR  = 3;
	localparam int BIT_CAPTURE_THREE = 2;
	localparam int BIT_SER_TWO_TX    = 1;
	localparam int BIT_SER_TWO_RX    = 0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int ACK_LATENCY = 1;

endpackage : pie_pkg

//--- pie_gate.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Flag gating: OR of each flag ANDed with its enable
// ----------------------------------------------------------------
module pie_gate #(
	parameter int WIDTH = 16
) (
	input  wire logic [WIDTH-1:0] flags,
	input  wire logic [WIDTH-1:0] enables,
	output logic      [WIDTH-1:0] pending,
	output logic                  any_pending
);

	initial begin
		if (WIDTH < 1)
			$error("pie_gate WIDTH must be at least 1");
	end

	// Masking per source, then reduction
	always_comb begin
		pending     = flags & enables;
		any_pending = |pending;
	end

endmodule : pie_gate

`default_nettype wire

//--- pie_timer_flag.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Flag sources for the second timer and second capture channel
// ----------------------------------------------------------------
// Sticky flags: set by hardware event, cleared by software pulse.
// A set in the same cycle as a clear wins so no event is lost.
module pie_timer_flag (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic timer_two_wrap,
	input  wire logic capture_two_event,
	input  wire logic clr_timer_two,
	input  wire logic clr_capture_two,
	output logic      timer_two_flag,
	output logic      capture_two_flag
);

	logic timer_q;
	logic timer_d;
	logic capture_q;
	logic capture_d;

	// Next state of both flags
	always_comb begin
		timer_d   = (timer_q & ~clr_timer_two) | timer_two_wrap;
		capture_d = (capture_q & ~clr_capture_two) | capture_two_event;
	end

	// Flag registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timer_q   <= 1'b0;
			capture_q <= 1'b0;
		end else begin
			timer_q   <= timer_d;
			capture_q <= capture_d;
		end
	end

	assign timer_two_flag   = timer_q;
	assign capture_two_flag = capture_q;

endmodule : pie_timer_flag

`default_nettype wire

//--- pie_enable_bank.sv
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Low bit 7 enables the port change flag request.
// - Low bit 6 enables the third timer flag request.
// - Low bit 5 enables the second timer period-match flag request.
// - Low bit 4 enables the first timer flag request.
// - Low bit 3 enables the second capture flag request.
// - Low bit 2 enables the first capture flag request.
// - Low bit 1 enables serial one transmit-empty request.
// - Low bit 0 enables serial one receive-full request.
// - High bit 6 enables the bus collision flag request.
// - High bit 1 enables serial two transmit-empty request.
// - Second timer flag sets when count wraps to zero after period match.
// - Second capture flag sets on each capture event of that channel.
module pie_enable_bank (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// Flag inputs, low register order
	input  wire logic        port_change_flag,
	input  wire logic        timer_three_flag,
	input  wire logic        timer_one_flag,
	input  wire logic        capture_one_flag,
	input  wire logic        serial_one_tx_flag,
	input  wire logic        serial_one_rx_flag,
	// Flag inputs, high register order
	input  wire logic        sync_serial_flag,
	input  wire logic        bus_collision_flag,
	input  wire logic        converter_flag,
	input  wire logic        capture_four_flag,
	input  wire logic        capture_three_flag,
	input  wire logic        serial_two_tx_flag,
	input  wire logic        serial_two_rx_flag,
	// Raw events for the locally held flags
	input  wire logic        timer_two_wrap,
	input  wire logic        capture_two_event,
	// Combined peripheral request
	output logic             periph_irq_req
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0]  en_lo_q;
	logic [7:0]  en_lo_d;
	logic [7:0]  en_hi_q;
	logic [7:0]  en_hi_d;
	logic        ack_q;
	logic        ack_d;
	logic        err_q;
	logic        err_d;
	logic [31:0] dat_q;
	logic [31:0] dat_d;
	logic        req_q;
	logic        req_d;
	logic        clr_t2;
	logic        clr_c2;
	logic        timer_two_flag;
	logic        capture_two_flag;
	logic [15:0] flags_all;
	logic [15:0] enables_all;
	logic        any_pending;
	logic [7:0]  word_idx;
	logic        access;
	logic        wr_lane0;

	// Address index from byte address
	function automatic logic [7:0] byte_to_idx(input logic [9:0] adr);
		byte_to_idx = adr[9:2];
	endfunction : byte_to_idx

	// ----------------------------------------------------------------
	// Locally held flags
	// ----------------------------------------------------------------
	pie_timer_flag u_flags (
		.clk_sys           (clk_sys),
		.rst               (rst),
		.timer_two_wrap    (timer_two_wrap),
		.capture_two_event (capture_two_event),
		.clr_timer_two     (clr_t2),
		.clr_capture_two   (clr_c2),
		.timer_two_flag    (timer_two_flag),
		.capture_two_flag  (capture_two_flag)
	);

	// Flag vector, low register in the bottom byte
	always_comb begin
		flags_all = {sync_serial_flag, bus_collision_flag, converter_flag,
			1'b0, capture_four_flag, capture_three_flag,
			serial_two_tx_flag, serial_two_rx_flag,
			port_change_flag, timer_three_flag, timer_two_flag,
			timer_one_flag, capture_two_flag, capture_one_flag,
			serial_one_tx_flag, serial_one_rx_flag};
		enables_all = {en_hi_q, en_lo_q};
	end

	// ----------------------------------------------------------------
	// Gating of every source
	// ----------------------------------------------------------------
	// Per-bit AND then OR; too
	pie_gate #(
		.WIDTH (16)
	) u_gate (
		.flags       (flags_all),
		.enables     (enables_all),
		.pending     (),
		.any_pending (any_pending)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Ack drops the cycle after it rises so a held request is not retaken
	always_comb begin
		word_idx = byte_to_idx(wb_adr_i);
		access   = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
		wr_lane0 = access & wb_we_i & wb_sel_i[0];
	end

	// Next register, answer and request values
	always_comb begin
		en_lo_d = en_lo_q;
		en_hi_d = en_hi_q;
		ack_d   = 1'b0;
		err_d   = 1'b0;
		dat_d   = dat_q;
		clr_t2  = 1'b0;
		clr_c2  = 1'b0;
		if (access) begin
			case (word_idx)
				pie_pkg::IDX_ENABLE_LO: begin
					if (wr_lane0)
						en_lo_d = wb_dat_i[7:0];
					dat_d = {24'h000000, en_lo_q};
					ack_d = 1'b1;
				end
				pie_pkg::IDX_ENABLE_HI: begin
					if (wr_lane0)
						en_hi_d = wb_dat_i[7:0] & pie_pkg::MASK_ENABLE_HI;
					dat_d = {24'h000000, en_hi_q};
					ack_d = 1'b1;
				end
				pie_pkg::IDX_FLAGS_LO: begin
					// Write one to clear the two local flags
					if (wr_lane0) begin
						clr_t2 = wb_dat_i[pie_pkg::BIT_TIMER_TWO];
						clr_c2 = wb_dat_i[pie_pkg::BIT_CAPTURE_TWO];
					end
					dat_d = {24'h000000, flags_all[7:0]};
					ack_d = 1'b1;
				end
				pie_pkg::IDX_FLAGS_HI: begin
					dat_d = {24'h000000, flags_all[15:8]};
					ack_d = 1'b1;
				end
				pie_pkg::IDX_STATUS: begin
					dat_d = {31'h00000000, req_q};
					ack_d = 1'b1;
				end
				default: begin
					dat_d = 32'h00000000;
					err_d = 1'b1;
				end
			endcase
		end
		req_d = any_pending;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_lo_q <= pie_pkg::RST_ENABLE_LO;
			en_hi_q <= pie_pkg::RST_ENABLE_HI;
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			dat_q   <= 32'h00000000;
			req_q   <= 1'b0;
		end else begin
			en_lo_q <= en_lo_d;
			en_hi_q <= en_hi_d;
			ack_q   <= ack_d;
			err_q   <= err_d;
			dat_q   <= dat_d;
			req_q   <= req_d;
		end
	end

	assign wb_ack_o       = ack_q;
	assign wb_err_o       = err_q;
	assign wb_dat_o       = dat_q;
	assign periph_irq_req = req_q;

endmodule : pie_enable_bank

`default_nettype wire

//--- pie_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port-level checks
// ----------------------------------------------------------------
module pie_checker (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [9:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        port_change_flag,
	input wire logic        serial_one_rx_flag,
	input wire logic        bus_collision_flag,
	input wire logic        serial_two_tx_flag,
	input wire logic        periph_irq_req
);
	logic [7:0] lo_q, lo_d, hi_q, hi_d;
	logic       tk, mp;
	logic [7:0] ix;
	// Request taken this edge; mirror at the same edge to avoid lag
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign ix = wb_adr_i[9:2];
	assign mp = ix inside {8'h11, 8'h17, 8'h18, 8'h19, 8'h1a};
	// Shadow of both enable registers
	always_comb begin
		lo_d = lo_q;
		hi_d = hi_q;
		if (tk && wb_we_i && wb_sel_i[0] && ix == pie_pkg::IDX_ENABLE_LO)
			lo_d = wb_dat_i[7:0];
		if (tk && wb_we_i && wb_sel_i[0] && ix == pie_pkg::IDX_ENABLE_HI)
			hi_d = wb_dat_i[7:0] & pie_pkg::MASK_ENABLE_HI;
	end
	// Register the shadow
	always_ff @(posedge clk_sys) begin
		lo_q <= rst ? 8'h00 : lo_d;
		hi_q <= rst ? 8'h00 : hi_d;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_ack; tk && mp |=> wb_ack_o && !wb_err_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_err; tk && !mp |=> wb_err_o && !wb_ack_o; endproperty
	a_err: assert property (p_err) else $error("no err");
	property p_rd_hi; wb_ack_o && !wb_we_i && ix == pie_pkg::IDX_ENABLE_HI
		|-> wb_dat_o == {24'h0, hi_q}; endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("hi read");
	property p_rd_lo; wb_ack_o && !wb_we_i && ix == pie_pkg::IDX_ENABLE_LO
		|-> wb_dat_o[7:0] == lo_q; endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("lo read");
	property p_pc; port_change_flag && lo_q[7] |=> periph_irq_req; endproperty
	a_pc: assert property (p_pc) else $error("port req");
	property p_rx; serial_one_rx_flag && lo_q[0] |=> periph_irq_req; endproperty
	a_rx: assert property (p_rx) else $error("rx req");
	property p_bc; bus_collision_flag && hi_q[6] |=> periph_irq_req; endproperty
	a_bc: assert property (p_bc) else $error("bcol req");
	property p_tx2; serial_two_tx_flag && hi_q[1] |=> periph_irq_req; endproperty
	a_tx2: assert property (p_tx2) else $error("tx2 req");
	property p_mask; lo_q == 8'h00 && hi_q == 8'h00 |=> !periph_irq_req;
	endproperty
	a_mask: assert property (p_mask) else $error("masked req");
endmodule : pie_checker
bind pie_enable_bank pie_checker pie_checker_i (.clk_sys(clk_sys), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.port_change_flag(port_change_flag), .serial_one_rx_flag(serial_one_rx_flag),
	.bus_collision_flag(bus_collision_flag),
	.serial_two_tx_flag(serial_two_tx_flag), .periph_irq_req(periph_irq_req));
`default_nettype wire

//--- pie_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Peripheral flag sources
// ----------------------------------------------------------------
module pie_partner (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [15:0] raise,
	output logic      [15:0] flag,
	output logic             timer_two_wrap,
	output logic             capture_two_event
);
	logic [15:0] prev_q;
	// Levels follow the request; slot 12 has no source
	assign flag = raise & 16'hefff;
	// Events fire once per rise, like a wrap or a capture edge
	assign timer_two_wrap = raise[5] && !prev_q[5];
	assign capture_two_event = raise[3] && !prev_q[3];
	// Previous request for edge detection
	always_ff @(posedge clk_sys) begin
		prev_q <= rst ? 16'h0000 : raise;
	end
endmodule : pie_partner
`default_nettype wire

//--- test_peripheral_irq_enable_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module test_peripheral_irq_enable_bank;
	logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, e;
	logic [9:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        wb_ack_o, wb_err_o, periph_irq_req, tw, ce;
	logic [15:0] raise, f, en;
	logic [7:0]  rd;
	int          n_mismatch, samples_checked;
	pie_enable_bank pie_enable_bank_i (.clk_sys(clk_sys), .rst(rst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.port_change_flag(f[7]), .timer_three_flag(f[6]),
		.timer_one_flag(f[4]), .capture_one_flag(f[2]),
		.serial_one_tx_flag(f[1]), .serial_one_rx_flag(f[0]),
		.sync_serial_flag(f[15]), .bus_collision_flag(f[14]),
		.converter_flag(f[13]), .capture_four_flag(f[11]),
		.capture_three_flag(f[10]), .serial_two_tx_flag(f[9]),
		.serial_two_rx_flag(f[8]), .timer_two_wrap(tw),
		.capture_two_event(ce), .periph_irq_req(periph_irq_req));
	pie_partner pie_partner_i (.clk_sys(clk_sys), .rst(rst), .raise(raise),
		.flag(f), .timer_two_wrap(tw), .capture_two_event(ce));
	// Free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task check(input string nm, input logic [7:0] x, input logic [7:0] g);
		samples_checked++;
		if (g !== x) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, x, g);
		end
	endtask : check
	// One classic cycle; answer taken at the edge that shows ack or err
	task wb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {ix, 2'b00};
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h000000, wd};
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_mismatch++;
			stop_test;
		end
		rd = wb_dat_o[7:0];
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
	endtask : wb
	// Reset, register checks, then one source at a time
	initial begin
		{rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		{wb_adr_i, wb_sel_i, wb_dat_i, raise} = '0;
		{n_mismatch, samples_checked} = '0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		wb(0, pie_pkg::IDX_ENABLE_LO, 8'h00);
		check("lo reset", pie_pkg::RST_ENABLE_LO, rd);
		wb(0, pie_pkg::IDX_ENABLE_HI, 8'h00);
		check("hi reset", 8'h00, rd);
		wb(1, pie_pkg::IDX_ENABLE_HI, 8'hff);
		wb(0, pie_pkg::IDX_ENABLE_HI, 8'h00);
		check("hi bit4", 8'hef, rd);
		wb(1, 8'h30, 8'h55);
		check("unmapped", 8'h01, {7'h00, e});
		for (int i = 0; i < 16; i++) if (i != 12) begin
			en = 16'h0001 << i;
			wb(1, pie_pkg::IDX_ENABLE_LO, en[7:0]);
			wb(1, pie_pkg::IDX_ENABLE_HI, en[15:8]);
			raise <= en;
			repeat (3) @(posedge clk_sys);
			check("req on", 8'h01, {7'h00, periph_irq_req});
			// Status word mirrors the registered request
			wb(0, pie_pkg::IDX_STATUS, 8'h00);
			check("status", 8'h01, rd);
			wb(1, pie_pkg::IDX_ENABLE_LO, 8'h00);
			wb(1, pie_pkg::IDX_ENABLE_HI, 8'h00);
			check("masked", 8'h00, {7'h00, periph_irq_req});
			wb(0, i < 8 ? pie_pkg::IDX_FLAGS_LO : pie_pkg::IDX_FLAGS_HI, 8'h00);
			check("flag", 8'h01 << (i % 8), rd & (8'h01 << (i % 8)));
			raise <= 16'h0000;
			wb(1, pie_pkg::IDX_FLAGS_LO, 8'h28);
		end
		// All enabled with no flag must stay quiet
		wb(1, pie_pkg::IDX_ENABLE_LO, 8'hff);
		wb(1, pie_pkg::IDX_ENABLE_HI, 8'hff);
		check("idle", 8'h00, {7'h00, periph_irq_req});
		stop_test;
	end
endmodule : test_peripheral_irq_enable_bank
`default_nettype wire
